//--- clrb_pkg.sv
`default_nettype none

package clrb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Command codes of the word registers
    localparam logic [7:0] CMD_CHARGE_VOLTAGE_CEILING = 8'h15;
    localparam logic [7:0] CMD_LIMIT_DURATION_CODES = 8'h38;
    localparam logic [7:0] CMD_ADAPTER_LIMIT_SECONDARY = 8'h3B;
    localparam logic [7:0] CMD_ADAPTER_LIMIT_PRIMARY = 8'h3F;

    ////////////////////////////////////////////////////////////////////////////
    // Field layouts
    localparam int WORD_W = 16;
    localparam int LIMIT_W = 11;
    localparam int LIMIT_LSB = 2;
    localparam int LIMIT_MSB = 12;
    localparam int CEIL_W = 11;
    localparam int CEIL_LSB = 3;
    localparam int CEIL_MSB = 13;
    localparam int DUR_W = 3;
    localparam int DUR_PRI_LSB = 0;
    localparam int DUR_PRI_MSB = 2;
    localparam int DUR_SEC_LSB = 8;
    localparam int DUR_SEC_MSB = 10;

    ////////////////////////////////////////////////////////////////////////////
    // Clamp ceilings and reset values (codes, not physical units)
    localparam logic [LIMIT_W-1:0] LIMIT_CODE_MAX = 11'h5F0;
    localparam logic [CEIL_W-1:0] CEIL_CODE_MAX = 11'h6C0;
    localparam logic [LIMIT_W-1:0] SEC_DEFAULT_CODE_4MA = 11'h177;
    localparam logic [LIMIT_W-1:0] SEC_DEFAULT_CODE_8MA = 11'h0BB;
    localparam logic [LIMIT_W-1:0] LIMIT_RESET_CODE = 11'h000;
    localparam logic [CEIL_W-1:0] CEIL_RESET_CODE = 11'h000;
    localparam logic [DUR_W-1:0] DUR_RESET_CODE = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Duration code to microseconds
    localparam logic [15:0] PRI_DUR_US [8] = '{16'h2710, 16'h4E20, 16'h3A98, 16'h1388,
                                              16'h03E8, 16'h01F4, 16'h0064, 16'h0000};
    localparam logic [15:0] SEC_DUR_US [8] = '{16'h000A, 16'h0064, 16'h01F4, 16'h03E8,
                                              16'h012C, 16'h02EE, 16'h07D0, 16'h2710};

    ////////////////////////////////////////////////////////////////////////////
    // Whole state of the register bank
    typedef struct packed {
        logic [LIMIT_W-1:0] limPri;
        logic [LIMIT_W-1:0] limSec;
        logic [DUR_W-1:0] durPri;
        logic [DUR_W-1:0] durSec;
        logic [CEIL_W-1:0] ceil;
        logic [WORD_W-1:0] rdData;
        logic rdValid;
        logic cmdMiss;
        logic adapterSeen;
        logic [15:0] priMa;
        logic [15:0] secMa;
        logic [15:0] priDurUs;
        logic [15:0] secDurUs;
        logic [15:0] fullMv;
        logic [15:0] sysMv;
        logic regSys;
    } clrb_state_t;

endpackage : clrb_pkg

`default_nettype wire

//--- clrb_sync.sv
`default_nettype none

// Two-stage level synchroniser for quasi-static pins
module clrb_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);

    // Refuse a chain too short to settle metastability
    initial begin
        if (STAGES < 2 || WIDTH < 1) begin
            $error("clrb_sync: STAGES must be at least 2 and WIDTH at least 1");
        end
    end

    // Shift chain; only the next stage reads each flop
    logic [STAGES-1:0][WIDTH-1:0] chain_q;

    // Register every stage on every rising edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chain_q <= '0;
        end else begin
            chain_q <= {chain_q[STAGES-2:0], pinIn};
        end
    end

    // Last stage is the clean level
    assign syncOut = chain_q[STAGES-1];

endmodule : clrb_sync

`default_nettype wire

//--- clrb_limit_bank.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Limit register bank behind the word command port
////////////////////////////////////////////////////////////////////////////////

// Function
// - Primary limit 0x3F, secondary 0x3B words
// - Keep valid bits, clamp current at 6080mA
// - 20 milliohm: bits 12:2, 4mA LSB
// - 10 milliohm: 8mA LSB, max 12160mA
// - Adapter arrival loads primary from strap
// - Secondary defaults 1.5A unless battery first
// - Both current limits read back stored value
// - Duration word 0x38 keeps valid fields
// - Primary duration code bits 2:0 table
// - Secondary duration code bits 10:8 table
// - Voltage ceiling written at command 0x15
// - Keep valid bits, clamp at 13.824V
// - Ceiling bits 13:3, 8mV LSB, max code
// - Ceiling: full charge and bus target
module clrb_limit_bank
    import clrb_pkg::*;
#(
    parameter int STRAP_W = 11,
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    // Word command port from the protocol engine
    input wire logic [7:0] cmdCode,
    input wire logic wrStrobe,
    input wire logic [15:0] wrData,
    input wire logic rdStrobe,
    output logic [15:0] rdData,
    output logic rdValid,
    output logic cmdMiss,
    // Pins from the analog side
    input wire logic [STRAP_W-1:0] limitStrapPin,
    input wire logic adapterPresentPin,
    input wire logic batteryPresentPin,
    input wire logic senseTenMilliPin,
    // Charger core status on this clock
    input wire logic chargingActive,
    // Decoded settings towards the regulation loops
    output logic [15:0] adapterLimitPrimaryMa,
    output logic [15:0] adapterLimitSecondaryMa,
    output logic [15:0] primaryDurationUs,
    output logic [15:0] secondaryDurationUs,
    output logic [15:0] fullChargeLimitMv,
    output logic [15:0] systemRegTargetMv,
    output logic regulateSystemBus
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // The strap decodes straight into the limit field, so widths must agree
    initial begin
        if (STRAP_W != LIMIT_W) begin
            $error("clrb_limit_bank: STRAP_W must equal the limit field width");
        end
        if (SYNC_STAGES < 2) begin
            $error("clrb_limit_bank: SYNC_STAGES must be at least 2");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    // Width of the bundle of pins that cross into this clock
    localparam int PIN_W = STRAP_W + 3;

    // Raw pin bundle
    logic [PIN_W-1:0] pinRaw;
    // Synchronised pin bundle
    logic [PIN_W-1:0] pinSync;

    // Strap is static while the adapter rises, so a plain per-bit chain is safe
    assign pinRaw = {limitStrapPin, adapterPresentPin, batteryPresentPin, senseTenMilliPin};

    // One synchroniser for every pin
    clrb_sync #(
        .WIDTH(PIN_W),
        .STAGES(SYNC_STAGES)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(pinRaw),
        .syncOut(pinSync)
    );

    // Clean strap code
    logic [LIMIT_W-1:0] strapCode;
    // Clean adapter level
    logic adapterPresent;
    // Clean battery level
    logic batteryPresent;
    // Clean sense resistor selection, high for 10 milliohm
    logic senseTenMilli;

    assign strapCode = pinSync[PIN_W-1 -: LIMIT_W];
    assign adapterPresent = pinSync[2];
    assign batteryPresent = pinSync[1];
    assign senseTenMilli = pinSync[0];

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Saturate a current limit code at the top of its range
    function automatic logic [LIMIT_W-1:0] clampLimit(input logic [LIMIT_W-1:0] code);
        logic [LIMIT_W-1:0] res;
        res = code;
        if (code > LIMIT_CODE_MAX) begin
            res = LIMIT_CODE_MAX;
        end
        return res;
    endfunction : clampLimit

    // Saturate a voltage ceiling code at the top of its range
    function automatic logic [CEIL_W-1:0] clampCeil(input logic [CEIL_W-1:0] code);
        logic [CEIL_W-1:0] res;
        res = code;
        if (code > CEIL_CODE_MAX) begin
            res = CEIL_CODE_MAX;
        end
        return res;
    endfunction : clampCeil

    // Scale a current code into milliamps for the chosen sense resistor
    function automatic logic [15:0] limitToMa(input logic [LIMIT_W-1:0] code, input logic tenMilli);
        logic [15:0] res;
        res = {3'h0, code, 2'h0};
        if (tenMilli) begin
            res = {2'h0, code, 3'h0};
        end
        return res;
    endfunction : limitToMa

    ////////////////////////////////////////////////////////////////////////////
    // State

    // Registered state
    clrb_state_t state_q;
    // Next state
    clrb_state_t state_d;

    // Decoded command hits
    logic hitPri;
    logic hitSec;
    logic hitDur;
    logic hitCeil;
    // Any known command
    logic hitAny;
    // Adapter arrival seen this cycle
    logic adapterRise;
    // Secondary default code for the active sense resistor
    logic [LIMIT_W-1:0] secDefault;

    assign hitPri = (cmdCode == CMD_ADAPTER_LIMIT_PRIMARY);
    assign hitSec = (cmdCode == CMD_ADAPTER_LIMIT_SECONDARY);
    assign hitDur = (cmdCode == CMD_LIMIT_DURATION_CODES);
    assign hitCeil = (cmdCode == CMD_CHARGE_VOLTAGE_CEILING);
    assign hitAny = hitPri | hitSec | hitDur | hitCeil;
    assign adapterRise = adapterPresent & ~state_q.adapterSeen;
    assign secDefault = senseTenMilli ? SEC_DEFAULT_CODE_8MA : SEC_DEFAULT_CODE_4MA;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // All register updates, the read path and the decoded outputs
    always_comb begin
        state_d = state_q;
        state_d.rdValid = 1'b0;
        state_d.cmdMiss = 1'b0;
        state_d.adapterSeen = adapterPresent;

        // Host writes keep only the field bits; the rest is dropped
        if (wrStrobe) begin
            if (hitPri) begin
                state_d.limPri = clampLimit(wrData[LIMIT_MSB:LIMIT_LSB]);
            end
            if (hitSec) begin
                state_d.limSec = clampLimit(wrData[LIMIT_MSB:LIMIT_LSB]);
            end
            if (hitDur) begin
                state_d.durPri = wrData[DUR_PRI_MSB:DUR_PRI_LSB];
                state_d.durSec = wrData[DUR_SEC_MSB:DUR_SEC_LSB];
            end
            if (hitCeil) begin
                state_d.ceil = clampCeil(wrData[CEIL_MSB:CEIL_LSB]);
            end
            if (!hitAny) begin
                // Unknown command: nothing stored, flag it
                state_d.cmdMiss = 1'b1;
            end
        end

        // Adapter arrival overrides a same-cycle primary write, and a secondary write when no battery is present
        if (adapterRise) begin
            state_d.limPri = clampLimit(strapCode);
            if (!batteryPresent) begin
                // Battery absent: no earlier setting to trust
                state_d.limSec = secDefault;
            end
        end

        // Read returns stored fields at their positions, zeros elsewhere
        if (rdStrobe) begin
            state_d.rdValid = 1'b1;
            state_d.rdData = '0;
            if (hitPri) begin
                state_d.rdData = {3'h0, state_q.limPri, 2'h0};
            end else if (hitSec) begin
                state_d.rdData = {3'h0, state_q.limSec, 2'h0};
            end else if (hitDur) begin
                state_d.rdData = {5'h00, state_q.durSec, 5'h00, state_q.durPri};
            end else if (hitCeil) begin
                state_d.rdData = {2'h0, state_q.ceil, 3'h0};
            end else begin
                // Unknown command reads as zero and is flagged
                state_d.cmdMiss = 1'b1;
            end
        end

        // Decoded physical values follow the stored codes one cycle later
        state_d.priMa = limitToMa(state_q.limPri, senseTenMilli);
        state_d.secMa = limitToMa(state_q.limSec, senseTenMilli);
        state_d.priDurUs = PRI_DUR_US[state_q.durPri];
        state_d.secDurUs = SEC_DUR_US[state_q.durSec];
        state_d.fullMv = {2'h0, state_q.ceil, 3'h0};
        // Bus regulation uses the ceiling unless a battery is charging
        state_d.regSys = ~batteryPresent | ~chargingActive;
        state_d.sysMv = state_d.regSys ? {2'h0, state_q.ceil, 3'h0} : 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Synchronous reset clears every field; the strap is caught later on arrival
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= '0;
            state_q.limPri <= LIMIT_RESET_CODE;
            state_q.limSec <= LIMIT_RESET_CODE;
            state_q.durPri <= DUR_RESET_CODE;
            state_q.durSec <= DUR_RESET_CODE;
            state_q.ceil <= CEIL_RESET_CODE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign rdData = state_q.rdData;
    assign rdValid = state_q.rdValid;
    assign cmdMiss = state_q.cmdMiss;
    assign adapterLimitPrimaryMa = state_q.priMa;
    assign adapterLimitSecondaryMa = state_q.secMa;
    assign primaryDurationUs = state_q.priDurUs;
    assign secondaryDurationUs = state_q.secDurUs;
    assign fullChargeLimitMv = state_q.fullMv;
    assign systemRegTargetMv = state_q.sysMv;
    assign regulateSystemBus = state_q.regSys;

endmodule : clrb_limit_bank

`default_nettype wire

//--- clrb_limit_bank_asserts.sv
`default_nettype none

// Port checks on the limit register bank; all on the one clock domain
module clrb_limit_bank_asserts
    import clrb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] cmdCode,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [15:0] rdData,
    input wire logic rdValid,
    input wire logic cmdMiss,
    input wire logic [15:0] adapterLimitPrimaryMa,
    input wire logic [15:0] fullChargeLimitMv
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Code names one of the four word registers
    logic known;
    assign known = cmdCode inside {CMD_CHARGE_VOLTAGE_CEILING, CMD_LIMIT_DURATION_CODES,
                                   CMD_ADAPTER_LIMIT_SECONDARY, CMD_ADAPTER_LIMIT_PRIMARY};

    ////////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (rdStrobe |=> rdValid)
        else $error("read not answered in one cycle");
    a_valid_cause: assert property (rdValid |-> $past(rdStrobe))
        else $error("read answer without a read");
    a_miss_decode: assert property ((wrStrobe || rdStrobe) |=> (cmdMiss == !$past(known)))
        else $error("command decode flag wrong");
    a_miss_zero: assert property (rdValid && !$past(known) |-> rdData == 16'h0000)
        else $error("unknown code read not zero");
    // Limit words: field 12:2 only, never above the clamp code
    a_limit_bits: assert property (rdValid && $past(cmdCode) inside {8'h3B, 8'h3F} |->
        rdData[15:13] == 3'h0 && rdData[1:0] == 2'h0 && rdData[12:2] <= LIMIT_CODE_MAX)
        else $error("limit word out of field");
    a_ceil_bits: assert property (rdValid && $past(cmdCode) == 8'h15 |->
        rdData[15:14] == 2'h0 && rdData[2:0] == 3'h0 && rdData[13:3] <= CEIL_CODE_MAX)
        else $error("ceiling word out of field");
    a_dur_bits: assert property (rdValid && $past(cmdCode) == 8'h38 |-> (rdData & 16'hF8F8) == 16'h0000)
        else $error("duration word has stray bits");
    // Primary current and ceiling voltage outputs stay on their step grid and within full scale
    a_cur_scale: assert property (adapterLimitPrimaryMa <= 16'h2F80 && adapterLimitPrimaryMa[1:0] == 2'h0)
        else $error("primary current beyond scale");
    a_volt_scale: assert property (fullChargeLimitMv <= 16'h3600 && fullChargeLimitMv[2:0] == 3'h0)
        else $error("ceiling voltage beyond scale");
endmodule : clrb_limit_bank_asserts

bind clrb_limit_bank clrb_limit_bank_asserts i_chk (.*);

`default_nettype wire

//--- clrb_host_model.sv
`default_nettype none

// Host side of the word command port: one request per call
module clrb_host_model (
    input wire logic clk,
    output logic [7:0] cmdCode,
    output logic wrStrobe,
    output logic [15:0] wrData,
    output logic rdStrobe,
    input wire logic [15:0] rdData,
    input wire logic rdValid,
    input wire logic cmdMiss
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        cmdCode = 8'h00;
        wrStrobe = 1'b0;
        wrData = 16'hA5A5;
        rdStrobe = 1'b0;
    end

    // Drive at the falling edge, hold over one taking edge, then sample
    task automatic word(input logic wr, input logic [7:0] cmd, input logic [15:0] data,
                        output logic [15:0] rd, output logic miss, output logic ok);
        @(negedge clk);
        cmdCode = cmd;
        wrData = data;
        wrStrobe = wr;
        rdStrobe = !wr;
        @(posedge clk);
        @(negedge clk);
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        // Unqualified lines carry junk so nothing leans on stale values
        cmdCode = ~cmd;
        wrData = ~data;
        rd = rdData;
        miss = cmdMiss;
        ok = (rdValid === !wr);
    endtask : word
endmodule : clrb_host_model

`default_nettype wire

//--- charger_limit_register_bank_tb.sv
`default_nettype none

module charger_limit_register_bank_tb
    import clrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] cmdCode;
    logic wrStrobe, rdStrobe, rdValid, cmdMiss, regulateSystemBus;
    logic [15:0] wrData, rdData, adapterLimitPrimaryMa, adapterLimitSecondaryMa;
    logic [15:0] primaryDurationUs, secondaryDurationUs, fullChargeLimitMv, systemRegTargetMv;
    logic [10:0] limitStrapPin = 11'h000;
    logic adapterPresentPin = 1'b0;
    logic batteryPresentPin = 1'b0;
    logic senseTenMilliPin = 1'b0;
    logic chargingActive = 1'b0;
    int mismatches = 0;
    int nTests = 0;
    // Duration tables in microseconds, by code
    logic [15:0] priTab [8] = '{16'h2710, 16'h4E20, 16'h3A98, 16'h1388, 16'h03E8, 16'h01F4, 16'h0064, 16'h0000};
    logic [15:0] secTab [8] = '{16'h000A, 16'h0064, 16'h01F4, 16'h03E8, 16'h012C, 16'h02EE, 16'h07D0, 16'h2710};

    always #20 clk = ~clk;

    clrb_limit_bank i_dut (.*);
    clrb_host_model i_host (.*);

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] r;
        logic m, v;
        i_host.word(1'b1, c, d, r, m, v);
    endtask : wr

    // Read one word; answer must come the cycle after the strobe
    task automatic rc(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] r;
        logic m, v;
        i_host.word(1'b0, c, 16'h0000, r, m, v);
        // Known code: answer valid and no decode miss
        chk({14'h0000, m, v}, 16'h0001);
        chk(r, e);
    endtask : rc

    ////////////////////////////////////////////////////////////////////////////
    task automatic tReset();
        rc(8'h3F, 16'h0000);
        rc(8'h38, 16'h0000);
        chk(secondaryDurationUs, 16'h000A);
        chk(primaryDurationUs, 16'h2710);
    endtask : tReset

    task automatic tLimits();
        wr(8'h3F, 16'hFFFF);
        rc(8'h3F, 16'h17C0);
        wr(8'h3B, 16'hE3B7);
        rc(8'h3B, 16'h03B4);
        chk(adapterLimitPrimaryMa, 16'h17C0);
        chk(adapterLimitSecondaryMa, 16'h03B4);
        senseTenMilliPin = 1'b1;
        cyc(5);
        chk(adapterLimitPrimaryMa, 16'h2F80);
        chk(adapterLimitSecondaryMa, 16'h0768);
        senseTenMilliPin = 1'b0;
    endtask : tLimits

    // Every code of both duration fields, stray bits set
    task automatic tDurations();
        for (int i = 0; i < 8; i++) begin
            wr(8'h38, 16'hF8F8 | {5'h00, i[2:0], 5'h00, i[2:0]});
            rc(8'h38, {5'h00, i[2:0], 5'h00, i[2:0]});
            chk(primaryDurationUs, priTab[i]);
            chk(secondaryDurationUs, secTab[i]);
        end
    endtask : tDurations

    // Reset in mid-run brings the duration codes back to their defaults
    task automatic tMidReset();
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        rc(8'h38, 16'h0000);
        chk(secondaryDurationUs, 16'h000A);
        chk(primaryDurationUs, 16'h2710);
    endtask : tMidReset

    task automatic tCeiling();
        wr(8'h15, 16'hFFFF);
        rc(8'h15, 16'h3600);
        chk(fullChargeLimitMv, 16'h3600);
        wr(8'h15, 16'hC00F);
        rc(8'h15, 16'h0008);
        chk({15'h0000, regulateSystemBus}, 16'h0001);
        chk(systemRegTargetMv, 16'h0008);
        batteryPresentPin = 1'b1;
        chargingActive = 1'b1;
        cyc(5);
        chk({15'h0000, regulateSystemBus}, 16'h0000);
        chk(systemRegTargetMv, 16'h0000);
        chk(fullChargeLimitMv, 16'h0008);
        chargingActive = 1'b0;
        cyc(3);
        chk(systemRegTargetMv, 16'h0008);
    endtask : tCeiling

    // Adapter arrival with and without the battery there first
    task automatic tAdapter();
        batteryPresentPin = 1'b0;
        limitStrapPin = 11'h7FF;
        cyc(4);
        adapterPresentPin = 1'b1;
        cyc(6);
        rc(8'h3F, 16'h17C0);
        rc(8'h3B, 16'h05DC);
        wr(8'h3B, 16'h0400);
        adapterPresentPin = 1'b0;
        batteryPresentPin = 1'b1;
        limitStrapPin = 11'h123;
        cyc(4);
        adapterPresentPin = 1'b1;
        cyc(6);
        rc(8'h3F, 16'h048C);
        rc(8'h3B, 16'h0400);
        // Third arrival, battery absent, 10 milliohm default code
        adapterPresentPin = 1'b0;
        batteryPresentPin = 1'b0;
        senseTenMilliPin = 1'b1;
        cyc(4);
        adapterPresentPin = 1'b1;
        cyc(6);
        rc(8'h3B, 16'h02EC);
        chk(adapterLimitSecondaryMa, 16'h05D8);
        senseTenMilliPin = 1'b0;
    endtask : tAdapter

    // Unmapped code: nothing stored, reads zero, flagged
    task automatic tRefused();
        logic [15:0] r;
        logic m, v;
        i_host.word(1'b1, 8'h3A, 16'hFFFF, r, m, v);
        chk({15'h0000, m}, 16'h0001);
        i_host.word(1'b0, 8'h3A, 16'h0000, r, m, v);
        chk({15'h0000, m}, 16'h0001);
        chk(r, 16'h0000);
        rc(8'h3F, 16'h048C);
    endtask : tRefused

    task automatic closeOut();
        $display("checks %0d mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : closeOut

    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        cyc(2);
        tReset();
        tLimits();
        tDurations();
        tMidReset();
        tCeiling();
        tAdapter();
        tRefused();
        closeOut();
    end

    // Whole run is about 120 cycles; this cuts off a hang
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        closeOut();
    end
endmodule : charger_limit_register_bank_tb

`default_nettype wire
